// ===== ltr_pkg.sv
/*
 * Shared constants and types for the link timeout, scratch, remote interrupt
 * routing and line width register bank.
 * Assumes a single 50 MHz core clock and an 8-bit register port.
 */
package ltr_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_LINK_TIMEOUT_CONTROL = 8'h26;
   localparam logic [7:0] ADDR_SCRATCH_REGISTER_A = 8'h2E;
   localparam logic [7:0] ADDR_SCRATCH_REGISTER_B = 8'h2F;
   localparam logic [7:0] ADDR_REMOTE_IRQ_ROUTING = 8'h30;
   localparam logic [7:0] ADDR_LINE_WIDTH_LOW = 8'h32;
   localparam logic [7:0] ADDR_LINE_WIDTH_HIGH = 8'h33;

   // ==========================================================
   // field widths and reset values
   localparam int SEL_W = 3;
   localparam int ROUTE_W = 4;
   localparam int LINE_W = 13;
   localparam int LINE_HI_W = 5;
   localparam logic [SEL_W-1:0] RST_LINK_TIMEOUT_SELECT = 3'h0;
   localparam logic [7:0] RST_SCRATCH_A = 8'hA5;
   localparam logic [7:0] RST_SCRATCH_B = 8'h5A;
   localparam logic [ROUTE_W-1:0] RST_REMOTE_IRQ_ROUTE = 4'h0;
   localparam logic [LINE_W-1:0] RST_LINE_WIDTH = 13'h0500;

   // ==========================================================
   // routing codes
   localparam logic [ROUTE_W-1:0] ROUTE_OFF = 4'h0;
   localparam logic [ROUTE_W-1:0] ROUTE_SPLIT = 4'h1;
   localparam logic [1:0] ROUTE_GENERAL_TOP = 2'h2;
   localparam logic [1:0] ROUTE_DATA_TOP = 2'h3;

   // ==========================================================
   // timeout figures in ns, and their cycle counts
   localparam int CLK_PERIOD_NS = 20;
   localparam int TO_162MS_NS = 162000000;
   localparam int TO_325MS_NS = 325000000;
   localparam int TO_650MS_NS = 650000000;
   localparam int TO_1P3MS_NS = 1300000;
   localparam int TO_10P25US_NS = 10250;
   localparam int TO_20P5US_NS = 20500;
   localparam int TO_41US_NS = 41000;
   localparam int TO_82US_NS = 82000;
   localparam int CYC_162MS = (TO_162MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_325MS = (TO_325MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_650MS = (TO_650MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_1P3MS = (TO_1P3MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_10P25US = (TO_10P25US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_20P5US = (TO_20P5US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_41US = (TO_41US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_82US = (TO_82US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TMR_W = 30;

   // ==========================================================
   // carriers and state
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ltr_reg_req_type;

   typedef struct packed {
      logic remote_irq_pin;
      logic local_irq_pin;
      logic [3:0] general_pin;
      logic [3:0] data_side_pin;
   } ltr_irq_out_type;

   typedef struct packed {
      logic [SEL_W-1:0] link_timeout_select;
      logic [7:0] scratch_a;
      logic [7:0] scratch_b;
      logic [ROUTE_W-1:0] remote_irq_route;
      logic [LINE_W-1:0] line_width;
      logic [7:0] rdata;
      logic rvalid;
      ltr_irq_out_type irq;
   } ltr_state_type;

   typedef enum logic [1:0] {
      TMR_DOWN = 2'b01,
      TMR_UP = 2'b10
   } ltr_tmr_mode_type;

   typedef struct packed {
      ltr_tmr_mode_type mode;
      logic [TMR_W-1:0] cnt;
   } ltr_tmr_state_type;

endpackage : ltr_pkg

// ===== ltr_link_timer.sv
/*
 * Reverse channel link detect timer.
 * Assumes the valid traffic pulse is already in the core clock domain.
 */
`timescale 1ns/100ps
module ltr_link_timer (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // reverse channel
   input wire logic rev_valid,
   input wire logic [ltr_pkg::TMR_W-1:0] limit,
   // status
   output logic detected
);
   import ltr_pkg::*;

   ltr_tmr_state_type s_r;
   ltr_tmr_state_type s_nxt;

   // ==========================================================
   // timer
   always_comb begin
      s_nxt = s_r;
      if (rev_valid) begin
         s_nxt.mode = TMR_UP;
         s_nxt.cnt = '0;
      end else begin
         unique case (s_r.mode)
            TMR_UP: begin
               if (s_r.cnt + TMR_W'(1) >= limit) begin
                  s_nxt.mode = TMR_DOWN;
                  s_nxt.cnt = '0;
               end else begin
                  s_nxt.cnt = s_r.cnt + TMR_W'(1);
               end
            end
            TMR_DOWN: begin
               s_nxt.cnt = '0;
            end
            default: begin
               s_nxt.mode = TMR_DOWN;
               s_nxt.cnt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '{mode: TMR_DOWN, cnt: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign detected = (s_r.mode == TMR_UP);

   // ==========================================================
   // checks
   a_valid_sets_detect: assert property (@(posedge clk) disable iff (!nrst)
      rev_valid |=> detected)
      else $error("detect not raised after valid traffic");
   a_expiry_drops_detect: assert property (@(posedge clk) disable iff (!nrst)
      (detected && !rev_valid && (s_r.cnt + TMR_W'(1) >= limit)) |=> !detected)
      else $error("detect held past the timeout");
   a_quiet_holds_detect: assert property (@(posedge clk) disable iff (!nrst)
      (detected && !rev_valid && (s_r.cnt + TMR_W'(1) < limit)) |=> detected)
      else $error("detect dropped before the timeout");
   c_link_lost: cover property (@(posedge clk) disable iff (!nrst)
      detected ##1 !detected);

endmodule : ltr_link_timer

// ===== ltr_regs.sv
/*
 * Register bank: link detect timeout, two scratch registers, remote
 * interrupt routing and the two-dimensional line width for the splitter.
 * Assumes an 8-bit register port in the core clock domain, decoded upstream
 * from the management bus, and interrupt sources on the same clock.
 */
`timescale 1ns/100ps
// What this block does
// - link detect drops when the timer expires without reverse traffic
// - three-bit select picks one of eight timeouts, reset 000
// - two free scratch registers, reset A5h and 5Ah
// - four-bit route selects interrupt pin, 0000 disables output
// - code 0001 puts port 0 on remote pin, port 1 on local pin
// - other codes output one interrupt: both ports combined, or port 0 alone when DUAL_LINK is set
// - 1000-1011 general pins, 1100-1111 data-side pins, 001x/01xx reserved
// - thirteen-bit line width split low/high, reset 0x500
// - splitter sees combined left/right line as twice the width
// - dual input left/right mode uses the same line width
module ltr_regs #(
   parameter int unsigned CYC_SEL0 = ltr_pkg::CYC_162MS,
   parameter int unsigned CYC_SEL1 = ltr_pkg::CYC_325MS,
   parameter int unsigned CYC_SEL2 = ltr_pkg::CYC_650MS,
   parameter int unsigned CYC_SEL3 = ltr_pkg::CYC_1P3MS,
   parameter int unsigned CYC_SEL4 = ltr_pkg::CYC_10P25US,
   parameter int unsigned CYC_SEL5 = ltr_pkg::CYC_20P5US,
   parameter int unsigned CYC_SEL6 = ltr_pkg::CYC_41US,
   parameter int unsigned CYC_SEL7 = ltr_pkg::CYC_82US
) (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // register port
   input wire ltr_pkg::ltr_reg_req_type REG_REQ,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   // reverse channel
   input wire logic REV_VALID,
   output logic LINK_DETECTED,
   // remote interrupts
   input wire logic PORT0_REM_IRQ,
   input wire logic PORT1_REM_IRQ,
   input wire logic DUAL_LINK,
   output ltr_pkg::ltr_irq_out_type IRQ_OUT,
   // splitter
   output logic [ltr_pkg::LINE_W-1:0] LINE_WIDTH,
   output logic [ltr_pkg::LINE_W:0] LINE_WIDTH_COMBINED
);
   import ltr_pkg::*;

   ltr_state_type s_r;
   ltr_state_type s_nxt;
   logic [TMR_W-1:0] limit;
   logic combined_irq;

   // ==========================================================
   // timeout selection
   always_comb begin
      unique case (s_r.link_timeout_select)
         3'h0: limit = TMR_W'(CYC_SEL0);
         3'h1: limit = TMR_W'(CYC_SEL1);
         3'h2: limit = TMR_W'(CYC_SEL2);
         3'h3: limit = TMR_W'(CYC_SEL3);
         3'h4: limit = TMR_W'(CYC_SEL4);
         3'h5: limit = TMR_W'(CYC_SEL5);
         3'h6: limit = TMR_W'(CYC_SEL6);
         3'h7: limit = TMR_W'(CYC_SEL7);
      endcase
   end

   ltr_link_timer u_timer (
      .clk(CLK),
      .nrst(NRST),
      .rev_valid(REV_VALID),
      .limit(limit),
      .detected(LINK_DETECTED)
   );

   // one interrupt for both ports unless dual link
   assign combined_irq = PORT0_REM_IRQ | (PORT1_REM_IRQ & ~DUAL_LINK);

   // ==========================================================
   // register writes, reads and routing
   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;
      if (REG_REQ.wr) begin
         // only defined fields take write data
         unique case (REG_REQ.addr)
            ADDR_LINK_TIMEOUT_CONTROL:
               s_nxt.link_timeout_select = REG_REQ.wdata[SEL_W-1:0];
            ADDR_SCRATCH_REGISTER_A: s_nxt.scratch_a = REG_REQ.wdata;
            ADDR_SCRATCH_REGISTER_B: s_nxt.scratch_b = REG_REQ.wdata;
            ADDR_REMOTE_IRQ_ROUTING:
               s_nxt.remote_irq_route = REG_REQ.wdata[ROUTE_W-1:0];
            ADDR_LINE_WIDTH_LOW: s_nxt.line_width[7:0] = REG_REQ.wdata;
            ADDR_LINE_WIDTH_HIGH:
               s_nxt.line_width[LINE_W-1:8] = REG_REQ.wdata[LINE_HI_W-1:0];
            default: begin
            end
         endcase
      end
      if (REG_REQ.rd) begin
         s_nxt.rvalid = 1'b1;
         unique case (REG_REQ.addr)
            ADDR_LINK_TIMEOUT_CONTROL: s_nxt.rdata = 8'(s_r.link_timeout_select);
            ADDR_SCRATCH_REGISTER_A: s_nxt.rdata = s_r.scratch_a;
            ADDR_SCRATCH_REGISTER_B: s_nxt.rdata = s_r.scratch_b;
            ADDR_REMOTE_IRQ_ROUTING: s_nxt.rdata = 8'(s_r.remote_irq_route);
            ADDR_LINE_WIDTH_LOW: s_nxt.rdata = s_r.line_width[7:0];
            ADDR_LINE_WIDTH_HIGH: s_nxt.rdata = 8'(s_r.line_width[LINE_W-1:8]);
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      // off and reserved codes drive nothing
      s_nxt.irq = '0;
      if (s_r.remote_irq_route == ROUTE_SPLIT) begin
         s_nxt.irq.remote_irq_pin = PORT0_REM_IRQ;
         s_nxt.irq.local_irq_pin = PORT1_REM_IRQ;
      end else if (s_r.remote_irq_route[3:2] == ROUTE_GENERAL_TOP) begin
         s_nxt.irq.general_pin[s_r.remote_irq_route[1:0]] = combined_irq;
      end else if (s_r.remote_irq_route[3:2] == ROUTE_DATA_TOP) begin
         s_nxt.irq.data_side_pin[s_r.remote_irq_route[1:0]] = combined_irq;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_r <= '{link_timeout_select: RST_LINK_TIMEOUT_SELECT,
                  scratch_a: RST_SCRATCH_A,
                  scratch_b: RST_SCRATCH_B,
                  remote_irq_route: RST_REMOTE_IRQ_ROUTE,
                  line_width: RST_LINE_WIDTH,
                  rdata: 8'h00,
                  rvalid: 1'b0,
                  irq: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign REG_RDATA = s_r.rdata;
   assign REG_RVALID = s_r.rvalid;
   assign IRQ_OUT = s_r.irq;
   // same width for split and dual input modes
   assign LINE_WIDTH = s_r.line_width;
   // combined left/right line is twice the width
   assign LINE_WIDTH_COMBINED = {s_r.line_width, 1'b0};

   // ==========================================================
   // checks
   a_timeout_select_map: assert property (@(posedge CLK) disable iff (!NRST)
      (s_r.link_timeout_select == 3'h4) |-> (limit == TMR_W'(CYC_SEL4)))
      else $error("timeout select 100 maps to wrong count");
   a_scratch_readback: assert property (@(posedge CLK) disable iff (!NRST)
      (REG_REQ.wr && REG_REQ.addr == ADDR_SCRATCH_REGISTER_A) ##1
      (REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == ADDR_SCRATCH_REGISTER_A)
      |=> (REG_RVALID && REG_RDATA == $past(REG_REQ.wdata, 2)))
      else $error("scratch a does not read back");
   a_route_off_quiet: assert property (@(posedge CLK) disable iff (!NRST)
      (s_r.remote_irq_route == ROUTE_OFF) |=> (IRQ_OUT == '0))
      else $error("interrupt driven while routing disabled");
   a_route_split: assert property (@(posedge CLK) disable iff (!NRST)
      (s_r.remote_irq_route == ROUTE_SPLIT) |=>
      (IRQ_OUT.remote_irq_pin == $past(PORT0_REM_IRQ)
       && IRQ_OUT.local_irq_pin == $past(PORT1_REM_IRQ)))
      else $error("split routing does not follow ports");
   a_route_general: assert property (@(posedge CLK) disable iff (!NRST)
      (s_r.remote_irq_route == 4'h9) |=>
      (IRQ_OUT.general_pin[1] == $past(combined_irq) && !IRQ_OUT.remote_irq_pin))
      else $error("general pin 1 routing wrong");
   a_route_combined: assert property (@(posedge CLK) disable iff (!NRST)
      (s_r.remote_irq_route == 4'hC && !DUAL_LINK && PORT1_REM_IRQ)
      |=> IRQ_OUT.data_side_pin[0])
      else $error("port 1 interrupt missing from combined output");
   a_reserved_read_zero: assert property (@(posedge CLK) disable iff (!NRST)
      (REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == ADDR_LINE_WIDTH_HIGH)
      |=> (REG_RDATA[7:LINE_HI_W] == 3'h0))
      else $error("reserved bits of line width high not zero");
   a_line_width_double: assert property (@(posedge CLK) disable iff (!NRST)
      LINE_WIDTH_COMBINED == {1'b0, LINE_WIDTH} + {1'b0, LINE_WIDTH})
      else $error("combined line width is not twice the width");
   a_line_low_write: assert property (@(posedge CLK) disable iff (!NRST)
      (REG_REQ.wr && REG_REQ.addr == ADDR_LINE_WIDTH_LOW) |=>
      (LINE_WIDTH[7:0] == $past(REG_REQ.wdata) && LINE_WIDTH[12:8] == $past(LINE_WIDTH[12:8])))
      else $error("line width low write wrong");
   c_split_route: cover property (@(posedge CLK) disable iff (!NRST)
      (s_r.remote_irq_route == ROUTE_SPLIT) ##1 IRQ_OUT.local_irq_pin);
   c_data_route: cover property (@(posedge CLK) disable iff (!NRST)
      IRQ_OUT.data_side_pin[3]);
   c_width_write: cover property (@(posedge CLK) disable iff (!NRST)
      REG_REQ.wr && REG_REQ.addr == ADDR_LINE_WIDTH_HIGH);

endmodule : ltr_regs

// ===== ltr_remote_model.sv
/*
 * Far-side model: remote deserializer sending reverse channel traffic
 * and holding its remote interrupt levels.
 * Assumes every task is called at a falling edge of the core clock.
 */
`timescale 1ns/100ps
module ltr_remote_model (
   // clock
   input wire logic clk,
   // far side outputs
   output logic rev_valid,
   output logic irq0,
   output logic irq1
);
   // ==========================================================
   // idle levels
   initial begin
      rev_valid = 1'b0;
      irq0 = 1'b0;
      irq1 = 1'b0;
   end

   // ==========================================================
   // reverse traffic
   // one-cycle pulses, gap idle cycles apart
   task automatic send_traffic(input int count, input int gap);
      for (int i = 0; i < count; i++) begin
         rev_valid = 1'b1;
         @(negedge clk);
         rev_valid = 1'b0;
         if (i < count - 1) repeat (gap) @(negedge clk);
      end
   endtask : send_traffic

   // ==========================================================
   // remote interrupt levels
   task automatic set_irq(input logic p0, input logic p1);
      irq0 = p0;
      irq1 = p1;
   endtask : set_irq
endmodule : ltr_remote_model

// ===== link_timeout_irq_route_line_regs_tb.sv
/*
 * Self-checking bench for the register bank with a far-side model.
 * Assumes the short timeout parameters below and 50 MHz core clock.
 */
`timescale 1ns/100ps
`define CHECK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin fail_count++; \
   $display("BAD %0t %s got %h exp %h", $time, msg, got, exp); end end
module link_timeout_irq_route_line_regs_tb;
   import ltr_pkg::*;
   // ==========================================================
   // signals
   localparam int N_TAB [8] = '{40, 60, 80, 20, 8, 10, 12, 16};
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   logic DUAL_LINK = 1'b0;
   ltr_reg_req_type REG_REQ = '0;
   logic [7:0] REG_RDATA;
   logic REG_RVALID, REV_VALID, LINK_DETECTED, PORT0_REM_IRQ, PORT1_REM_IRQ;
   ltr_irq_out_type IRQ_OUT;
   logic [LINE_W-1:0] LINE_WIDTH;
   logic [LINE_W:0] LINE_WIDTH_COMBINED;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;

   always #10 CLK = ~CLK;

   ltr_regs #(.CYC_SEL0(40), .CYC_SEL1(60), .CYC_SEL2(80), .CYC_SEL3(20),
      .CYC_SEL4(8), .CYC_SEL5(10), .CYC_SEL6(12), .CYC_SEL7(16)) u_ltr_regs (
      .CLK(CLK), .NRST(NRST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
      .REG_RVALID(REG_RVALID), .REV_VALID(REV_VALID), .LINK_DETECTED(LINK_DETECTED),
      .PORT0_REM_IRQ(PORT0_REM_IRQ), .PORT1_REM_IRQ(PORT1_REM_IRQ),
      .DUAL_LINK(DUAL_LINK), .IRQ_OUT(IRQ_OUT), .LINE_WIDTH(LINE_WIDTH),
      .LINE_WIDTH_COMBINED(LINE_WIDTH_COMBINED));

   ltr_remote_model u_ltr_remote_model (.clk(CLK), .rev_valid(REV_VALID),
      .irq0(PORT0_REM_IRQ), .irq1(PORT1_REM_IRQ));

   // ==========================================================
   // shared tasks
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test;
      end
   end

   // one request cycle; a read is judged the cycle after it is taken
   task automatic acc(input logic w, input logic r, input logic [7:0] a,
         input logic [7:0] d, input logic [7:0] exp);
      @(negedge CLK);
      REG_REQ = '{wr: w, rd: r, addr: a, wdata: d};
      @(negedge CLK);
      REG_REQ = '0;
      if (r) begin
         `CHECK(REG_RVALID, 1'b1, "read valid")
         `CHECK(REG_RDATA, exp, "read data")
      end
   endtask : acc

   function automatic ltr_irq_out_type exp_irq(input logic [3:0] r, input logic p0,
         input logic p1, input logic d);
      ltr_irq_out_type e;
      logic c;
      e = '0;
      c = p0 | (p1 & ~d);
      if (r == ROUTE_SPLIT) begin
         e.remote_irq_pin = p0;
         e.local_irq_pin = p1;
      end else if (r[3] && r[2]) begin
         e.data_side_pin[r[1:0]] = c;
      end else if (r[3]) begin
         e.general_pin[r[1:0]] = c;
      end
      return e;
   endfunction : exp_irq

   // ==========================================================
   // scenarios
   task automatic t_reset;
      acc(0, 1, ADDR_LINK_TIMEOUT_CONTROL, 0, 8'h00);
      acc(0, 1, ADDR_SCRATCH_REGISTER_A, 0, 8'hA5);
      acc(0, 1, ADDR_SCRATCH_REGISTER_B, 0, 8'h5A);
      acc(0, 1, ADDR_REMOTE_IRQ_ROUTING, 0, 8'h00);
      acc(0, 1, ADDR_LINE_WIDTH_LOW, 0, 8'h00);
      acc(0, 1, ADDR_LINE_WIDTH_HIGH, 0, 8'h05);
      `CHECK(LINE_WIDTH, 13'h0500, "reset width")
      `CHECK(LINE_WIDTH_COMBINED, 14'h0A00, "reset combined")
      `CHECK(IRQ_OUT, 10'h000, "reset irq")
      `CHECK(LINK_DETECTED, 1'b0, "reset link")
      $display("test reset done");
   endtask : t_reset

   task automatic t_scratch;
      acc(1, 1, ADDR_SCRATCH_REGISTER_B, 8'h3C, 8'h5A);
      acc(0, 1, ADDR_SCRATCH_REGISTER_B, 0, 8'h3C);
      acc(1, 0, ADDR_SCRATCH_REGISTER_A, 8'hC3, 0);
      acc(0, 1, ADDR_SCRATCH_REGISTER_A, 0, 8'hC3);
      acc(0, 1, ADDR_SCRATCH_REGISTER_B, 0, 8'h3C);
      acc(1, 0, ADDR_LINK_TIMEOUT_CONTROL, 8'hFA, 0);
      acc(0, 1, ADDR_LINK_TIMEOUT_CONTROL, 0, 8'h02);
      acc(1, 0, ADDR_REMOTE_IRQ_ROUTING, 8'hF0, 0);
      acc(0, 1, ADDR_REMOTE_IRQ_ROUTING, 0, 8'h00);
      acc(1, 0, 8'h31, 8'hFF, 0);
      acc(0, 1, 8'h31, 0, 8'h00);
      `CHECK(IRQ_OUT, 10'h000, "no side effect")
      $display("test scratch done");
   endtask : t_scratch

   task automatic t_line;
      // software stays at or below 4096 pixels
      acc(1, 0, ADDR_LINE_WIDTH_LOW, 8'h00, 0);
      acc(1, 0, ADDR_LINE_WIDTH_HIGH, 8'hF0, 0);
      acc(0, 1, ADDR_LINE_WIDTH_HIGH, 0, 8'h10);
      `CHECK(LINE_WIDTH, 13'h1000, "width 4096")
      `CHECK(LINE_WIDTH_COMBINED, 14'h2000, "combined 8192")
      acc(1, 0, ADDR_LINE_WIDTH_LOW, 8'h7F, 0);
      acc(1, 0, ADDR_LINE_WIDTH_HIGH, 8'h03, 0);
      acc(0, 1, ADDR_LINE_WIDTH_LOW, 0, 8'h7F);
      `CHECK(LINE_WIDTH, 13'h037F, "width low high")
      `CHECK(LINE_WIDTH_COMBINED, 14'h06FE, "combined twice")
      $display("test line done");
   endtask : t_line

   task automatic t_timer;
      int cnt;
      for (int s = 0; s < 8; s++) begin
         acc(1, 0, ADDR_LINK_TIMEOUT_CONTROL, 8'(s), 0);
         u_ltr_remote_model.send_traffic(2, N_TAB[s] / 2);
         cnt = 0;
         while (LINK_DETECTED === 1'b1 && cnt < 200) begin
            cnt++;
            @(negedge CLK);
         end
         `CHECK(cnt, N_TAB[s], "timeout cycles")
      end
      $display("test timer done");
   endtask : t_timer

   task automatic t_irq;
      logic [2:0] pat [3] = '{3'b100, 3'b010, 3'b011};
      for (int r = 0; r < 16; r++) begin
         acc(1, 0, ADDR_REMOTE_IRQ_ROUTING, 8'(r), 0);
         for (int k = 0; k < 3; k++) begin
            u_ltr_remote_model.set_irq(pat[k][2], pat[k][1]);
            DUAL_LINK = pat[k][0];
            repeat (3) @(negedge CLK);
            `CHECK(IRQ_OUT, exp_irq(4'(r), pat[k][2], pat[k][1], pat[k][0]), "irq")
         end
      end
      u_ltr_remote_model.set_irq(1'b1, 1'b1);
      acc(1, 0, ADDR_REMOTE_IRQ_ROUTING, 8'h01, 0);
      repeat (2) @(negedge CLK);
      `CHECK(IRQ_OUT, 10'h300, "both split pins")
      acc(1, 0, ADDR_REMOTE_IRQ_ROUTING, 8'h00, 0);
      repeat (2) @(negedge CLK);
      `CHECK(IRQ_OUT, 10'h000, "route off")
      $display("test irq done");
   endtask : t_irq

   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(negedge CLK);
      NRST = 1'b1;
      t_reset();
      t_scratch();
      t_line();
      t_timer();
      t_irq();
      finish_test();
   end
endmodule : link_timeout_irq_route_line_regs_tb
